// *** hw/guard_timer_pkg.sv ***
// Constants shared by the guard timer and its write lock.
// Assumes a single cpu clock domain; field layouts refer to the key register byte.
//
// Notes on behaviour
// RULE_01: Mode 11, key 10011 opens protected writes.
// RULE_02: Key 10101 closes protected writes.
// RULE_03: Open or close key leaves mode alone.
// RULE_04: Only key 11000 updates the mode field.
// RULE_05: Open access closes itself after 32 cycles.
// RULE_06: Repeated open key restarts the 32 cycles.
// RULE_07: Dividers, timer enable, power/slow-down are protected.
// RULE_08: Locked writes to protected bits are dropped.
// RULE_09: Unserviced overflow raises request and prewarning.
// RULE_10: Prewarning lasts 30 hex counts, then reset.
// RULE_11: Refresh inside window: prewarning, no request.
// RULE_12: Window spans 0000 to boundary byte, 00.
// RULE_13: Service reloads counter with reload byte, 00.
// RULE_14: Input clock is pclk/2 or pclk/128.
// RULE_15: Reload high byte is software programmable.
// RULE_16: Period follows prescale and reload byte formula.
// RULE_17: Window boundary above reload shortens the period.
// RULE_18: Software keeps boundary byte not below reload.
// RULE_19: Window disabled: every refresh is accepted.
package guard_timer_pkg;

    // Key register fields
    localparam int PASS_LSB = 3;
    localparam int PASS_W = 5;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;

    // Key codes and mode values
    localparam logic [4:0] PASS_OPEN = 5'h13;
    localparam logic [4:0] PASS_CLOSE = 5'h15;
    localparam logic [4:0] PASS_MODE = 5'h18;
    localparam logic [1:0] MODE_LOCKED = 2'h3;
    localparam logic [1:0] MODE_RST = 2'h3;

    // Access window length in cpu clocks
    localparam int OPEN_CYCLES = 32;
    localparam logic [5:0] OPEN_CNT = 6'(OPEN_CYCLES);

    // Prescale ratios and prewarning length in timer counts
    localparam int PRESCALE_FAST = 2;
    localparam int PRESCALE_SLOW = 128;
    localparam logic [7:0] PREWARN_COUNTS = 8'h30;

    // Reset values of the protected bits and the timer
    localparam int FBDIV_W_DEF = 4;
    localparam int OUTDIV_W_DEF = 1;
    localparam logic [3:0] FBDIV_RST = 4'h0;
    localparam logic [0:0] OUTDIV_RST = 1'h0;
    localparam logic GT_EN_RST = 1'b0;
    localparam logic PWRDN_EN_RST = 1'b0;
    localparam logic SLOWDN_EN_RST = 1'b0;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;

    // Timer supervision states
    typedef enum logic [1:0] {
        GT_RUN,
        GT_PREWARN,
        GT_RESET
    } gt_state_e;

endpackage

// *** hw/guard_timer_prescaler.sv ***
// Input prescaler for the guard timer counter.
// Assumes the enable is synchronous to clk and reset is already synchronised.
`timescale 1ns/100ps
`default_nettype none

module guard_timer_prescaler #(
    parameter int DIV_FAST = guard_timer_pkg::PRESCALE_FAST,
    parameter int DIV_SLOW = guard_timer_pkg::PRESCALE_SLOW
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic slow_sel,
    output logic tick
);
    import guard_timer_pkg::*;

    localparam int CW = $clog2(DIV_SLOW);

    // Both ratios share one counter, so they must be nested powers of two
    initial begin
        if (DIV_FAST < 2 || DIV_SLOW <= DIV_FAST ||
            (DIV_FAST & (DIV_FAST - 1)) != 0 || (DIV_SLOW & (DIV_SLOW - 1)) != 0) begin
            $error("guard_timer_prescaler: ratios must be powers of two, fast < slow");
        end
    end

    logic [CW-1:0] div_q;
    localparam logic [CW-1:0] FAST_MASK = CW'(DIV_FAST - 1);
    localparam logic [CW-1:0] SLOW_MASK = CW'(DIV_SLOW - 1);

    // Free running divider, cleared while the timer is stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
        end else if (!run) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + CW'(1);
        end
    end

    // One-cycle enable per selected ratio [RULE_14]
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else if (slow_sel) begin
            tick <= run && ((div_q & SLOW_MASK) == SLOW_MASK);
        end else begin
            tick <= run && ((div_q & FAST_MASK) == FAST_MASK);
        end
    end

endmodule // guard_timer_prescaler
`default_nettype wire

// *** hw/guard_timer_top.sv ***
// Windowed guard timer with a key-gated write lock on critical control bits.
// Assumes all software strobes come from logic on ref_clk (the cpu clock);
// only reset_n is asynchronous. The timer counts on ref_clk through a prescaler.
`timescale 1ns/100ps
`default_nettype none

module guard_timer_top #(
    parameter int FBDIV_W = guard_timer_pkg::FBDIV_W_DEF,
    parameter int OUTDIV_W = guard_timer_pkg::OUTDIV_W_DEF
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    // Key register write
    input wire logic key_wr,
    input wire logic [7:0] key_wdata,
    // Protected control write
    input wire logic prot_wr,
    input wire logic [FBDIV_W-1:0] pll_feedback_divider_wdata,
    input wire logic [OUTDIV_W-1:0] pll_output_divider_wdata,
    input wire logic guard_timer_enable_wdata,
    input wire logic power_down_enable_wdata,
    input wire logic slow_down_enable_wdata,
    // Unprotected timer configuration
    input wire logic [7:0] reload_high_byte,
    input wire logic [7:0] window_boundary_byte,
    input wire logic input_prescale_select,
    input wire logic window_enable,
    input wire logic service_req,
    // Protected bits as held
    output logic [FBDIV_W-1:0] pll_feedback_divider,
    output logic [OUTDIV_W-1:0] pll_output_divider,
    output logic guard_timer_enable,
    output logic power_down_enable,
    output logic slow_down_enable,
    // Lock status
    output logic [1:0] lock_mode,
    output logic write_open,
    // Timer status and requests
    output logic [15:0] timer_count,
    output logic prewarning,
    output logic invalid_refresh,
    output logic guard_timer_nmi_request,
    output logic guard_timer_reset_request
);
    import guard_timer_pkg::*;

    // Field widths must fit their reset values
    initial begin
        if (FBDIV_W < 4 || FBDIV_W > 8 || OUTDIV_W < 1 || OUTDIV_W > 8) begin
            $error("guard_timer_top: divider field widths out of range");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    ////////////////////////////////////////////////////////////////////////////

    logic rst_meta_q;
    logic rst_n_q;

    // Asserts at once, releases after two edges to avoid a ragged release
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Key decode and write lock
    ////////////////////////////////////////////////////////////////////////////

    logic [PASS_W-1:0] key_pass;
    logic [MODE_W-1:0] key_mode;
    logic locked_mode;
    logic key_open;
    logic key_close;
    logic key_mode_wr;
    logic [5:0] open_cnt_q;
    logic [5:0] open_cnt_d;
    logic prot_allowed;

    assign key_pass = key_wdata[PASS_LSB +: PASS_W];
    assign key_mode = key_wdata[MODE_LSB +: MODE_W];
    assign locked_mode = (lock_mode == MODE_LOCKED);

    // Open only counts while the scheme is armed [RULE_01]
    assign key_open = key_wr && locked_mode && (key_pass == PASS_OPEN);
    // Close honoured whenever protection is active [RULE_02]
    assign key_close = key_wr && locked_mode && (key_pass == PASS_CLOSE);
    // Mode is only taken with the mode code in the key field [RULE_04]
    assign key_mode_wr = key_wr && (key_pass == PASS_MODE);

    // Mode field; open/close codes never reach it [RULE_03] [RULE_04]
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_mode <= MODE_RST;
        end else if (key_mode_wr) begin
            lock_mode <= key_mode;
        end
    end

    // Access window counter in cpu clocks
    always_comb begin
        open_cnt_d = open_cnt_q;
        if (key_open) begin
            open_cnt_d = OPEN_CNT; // Reopen restarts the full count [RULE_06]
        end else if (key_close || !locked_mode) begin
            open_cnt_d = 6'h00; // [RULE_02]
        end else if (open_cnt_q != 6'h00) begin
            open_cnt_d = open_cnt_q - 6'h01; // Self close at expiry [RULE_05]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            open_cnt_q <= 6'h00;
        end else begin
            open_cnt_q <= open_cnt_d;
        end
    end

    // Registered view of the window, so status lags the key by one cycle
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            write_open <= 1'b0;
        end else begin
            write_open <= (open_cnt_d != 6'h00);
        end
    end

    // Unlocked mode lets every write through; armed mode needs an open window
    assign prot_allowed = !locked_mode || (open_cnt_q != 6'h00); // [RULE_01] [RULE_08]

    ////////////////////////////////////////////////////////////////////////////
    // Protected control bits
    ////////////////////////////////////////////////////////////////////////////

    // Dividers and enables; a refused write leaves them untouched [RULE_07] [RULE_08]
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pll_feedback_divider <= FBDIV_W'(FBDIV_RST);
            pll_output_divider <= OUTDIV_W'(OUTDIV_RST);
        end else if (prot_wr && prot_allowed) begin
            pll_feedback_divider <= pll_feedback_divider_wdata; // [RULE_07]
            pll_output_divider <= pll_output_divider_wdata; // [RULE_07]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            guard_timer_enable <= GT_EN_RST;
            power_down_enable <= PWRDN_EN_RST;
            slow_down_enable <= SLOWDN_EN_RST;
        end else if (prot_wr && prot_allowed) begin
            guard_timer_enable <= guard_timer_enable_wdata; // [RULE_07]
            power_down_enable <= power_down_enable_wdata; // [RULE_07]
            slow_down_enable <= slow_down_enable_wdata; // [RULE_07]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter clock
    ////////////////////////////////////////////////////////////////////////////

    logic count_tick;
    logic timer_run;

    // Prescaler stops once the reset request is out; nothing left to time
    assign timer_run = guard_timer_enable && !guard_timer_reset_request;

    guard_timer_prescaler #(
        .DIV_FAST(PRESCALE_FAST),
        .DIV_SLOW(PRESCALE_SLOW)
    ) u_prescaler (
        .clk(ref_clk),
        .rst_n(rst_n_q),
        .run(timer_run),
        .slow_sel(input_prescale_select), // [RULE_14] [RULE_16]
        .tick(count_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Service, window check and overflow
    ////////////////////////////////////////////////////////////////////////////

    gt_state_e state_q;
    gt_state_e state_d;
    logic [15:0] window_top;
    logic [15:0] reload_value;
    logic in_window;
    logic service_ok;
    logic service_bad;
    logic overflow;
    logic [7:0] pre_cnt_q;
    logic pre_done;

    // Window runs from zero up to boundary byte with a cleared low byte [RULE_12]
    assign window_top = {window_boundary_byte, 8'h00};
    // Reload sets only the upper byte [RULE_13] [RULE_15]
    assign reload_value = {reload_high_byte, 8'h00};
    assign in_window = (timer_count <= window_top); // [RULE_12]

    // Only a running, non-warning timer accepts a service
    // Window off means every refresh is good [RULE_19]
    assign service_ok = service_req && guard_timer_enable && (state_q == GT_RUN) &&
                        !(window_enable && in_window);
    // Refresh inside the window is invalid [RULE_11]
    assign service_bad = service_req && guard_timer_enable && (state_q == GT_RUN) &&
                         window_enable && in_window;
    // Roll past the top while unserviced [RULE_09]
    assign overflow = count_tick && (state_q == GT_RUN) && (timer_count == COUNT_MAX)
                      && !service_ok;
    assign pre_done = count_tick && (pre_cnt_q == PREWARN_COUNTS - 8'h01);

    // Counter: service wins over a tick in the same cycle. A boundary above the
    // reload byte makes early refreshes illegal, which shortens the usable
    // period by the same formula with the boundary byte [RULE_16] [RULE_17]
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            timer_count <= COUNT_RST;
        end else if (!guard_timer_enable) begin
            timer_count <= reload_value; // Parked at reload while disabled
        end else if (service_ok) begin
            timer_count <= reload_value; // [RULE_13]
        end else if (count_tick && state_q == GT_RUN) begin
            timer_count <= timer_count + 16'h0001; // Wraps to zero on overflow
        end
    end

    // Supervision sequence
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            GT_RUN: begin
                if (overflow || service_bad) begin
                    state_d = GT_PREWARN; // [RULE_09] [RULE_11]
                end
            end
            GT_PREWARN: begin
                if (pre_done) begin
                    state_d = GT_RESET; // [RULE_10]
                end
            end
            GT_RESET: begin
                state_d = GT_RESET; // Held until the system resets us
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= GT_RUN;
        end else if (!guard_timer_enable && state_q == GT_RUN) begin
            state_q <= GT_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Prewarning length counted in timer ticks [RULE_10]
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pre_cnt_q <= 8'h00;
        end else if (state_q != GT_PREWARN) begin
            pre_cnt_q <= 8'h00;
        end else if (count_tick) begin
            pre_cnt_q <= pre_cnt_q + 8'h01; // [RULE_10]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Requests and status
    ////////////////////////////////////////////////////////////////////////////

    // Non-maskable request only for a true overflow, held through the end [RULE_09]
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            guard_timer_nmi_request <= 1'b0;
        end else if (overflow) begin
            guard_timer_nmi_request <= 1'b1; // [RULE_09]
        end
    end

    // Marks a prewarning caused by a bad refresh; no non-maskable request goes out [RULE_11]
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            invalid_refresh <= 1'b0;
        end else if (service_bad) begin
            invalid_refresh <= 1'b1; // [RULE_11]
        end
    end

    // Prewarning level mirrors the state, in step with state_q
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            prewarning <= 1'b0;
        end else begin
            prewarning <= (state_d == GT_PREWARN);
        end
    end

    // Reset request is sticky; only a device reset takes it away [RULE_10]
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            guard_timer_reset_request <= 1'b0;
        end else if (state_q == GT_PREWARN && pre_done) begin
            guard_timer_reset_request <= 1'b1; // [RULE_10]
        end
    end

endmodule // guard_timer_top
`default_nettype wire

// *** test/guard_timer_properties.sv ***
// Checker for guard_timer_top: key lock, protected writes, timer supervision.
// Bound into every guard_timer_top; sees only its ports, all on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module guard_timer_properties
    import guard_timer_pkg::*;
#(
    parameter int FBDIV_W = FBDIV_W_DEF
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic key_wr,
    input wire logic [7:0] key_wdata,
    input wire logic prot_wr,
    input wire logic [FBDIV_W-1:0] pll_feedback_divider_wdata,
    input wire logic guard_timer_enable_wdata,
    input wire logic [7:0] reload_high_byte,
    input wire logic [7:0] window_boundary_byte,
    input wire logic input_prescale_select,
    input wire logic window_enable,
    input wire logic service_req,
    input wire logic [FBDIV_W-1:0] pll_feedback_divider,
    input wire logic guard_timer_enable,
    input wire logic [1:0] lock_mode,
    input wire logic write_open,
    input wire logic [15:0] timer_count,
    input wire logic prewarning,
    input wire logic invalid_refresh,
    input wire logic guard_timer_nmi_request,
    input wire logic guard_timer_reset_request
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    // Decoded key writes and refresh qualifiers
    wire logic armed = lock_mode == MODE_LOCKED;
    wire logic [1:0] mode_in = key_wdata[1:0];
    wire logic k_open = key_wr && armed && key_wdata[7:3] == PASS_OPEN;
    wire logic k_close = key_wr && armed && key_wdata[7:3] == PASS_CLOSE;
    wire logic k_mode = key_wr && key_wdata[7:3] == PASS_MODE;
    wire logic in_win = window_enable && timer_count <= {window_boundary_byte, 8'h00};
    wire logic srv_ok = service_req && guard_timer_enable && !prewarning
        && !guard_timer_reset_request && !in_win;
    logic [5:0] open_age;
    logic open_live;
    logic [15:0] pw_len;

    // Age of the last open key; saturates so a stale open never looks fresh
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) open_age <= 6'h21;
        else if (k_open) open_age <= 6'h01;
        else if (open_age != 6'h21) open_age <= open_age + 6'h01;
    end

    // Window still owed; a mode write drops the claim since its effect is open
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) open_live <= 1'b0;
        else if (k_open) open_live <= 1'b1;
        else if (k_close || k_mode) open_live <= 1'b0;
    end

    // Cycles spent in prewarning; one prewarning per reset at most
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) pw_len <= 16'h0000;
        else if (prewarning) pw_len <= pw_len + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    chk_open_key: assert property (k_open |=> write_open)
        else $error("open key left writes closed");
    chk_close_key: assert property (k_close |=> !write_open)
        else $error("close key left writes open");
    chk_mode_kept: assert property (key_wr && !k_mode |=> $stable(lock_mode))
        else $error("mode changed by a non-mode key");
    chk_mode_load: assert property (k_mode |=> lock_mode == $past(mode_in))
        else $error("mode key did not load the mode");
    chk_open_len: assert property (write_open |-> open_age <= 6'(OPEN_CYCLES))
        else $error("writes open beyond the access window");
    chk_open_hold: assert property (open_live && open_age <= 6'h20 |-> write_open)
        else $error("writes closed early");
    chk_locked_drop: assert property (prot_wr && armed && !write_open
        |=> $stable(guard_timer_enable) && $stable(pll_feedback_divider))
        else $error("locked write changed a protected bit");
    chk_prot_take: assert property (prot_wr && (!armed || write_open)
        |=> guard_timer_enable == $past(guard_timer_enable_wdata)
        && pll_feedback_divider == $past(pll_feedback_divider_wdata))
        else $error("open write not taken");
    chk_nmi_cause: assert property ($rose(guard_timer_nmi_request)
        |-> prewarning && $past(timer_count) == COUNT_MAX)
        else $error("nmi without overflow");
    chk_prewarn_len: assert property ($rose(guard_timer_reset_request)
        && !input_prescale_select |-> pw_len >= 16'd95 && pw_len <= 16'd97 && !prewarning)
        else $error("prewarning length wrong");
    chk_bad_refresh: assert property ($rose(invalid_refresh) |-> prewarning
        && !guard_timer_nmi_request && $past(service_req) && $past(window_enable))
        else $error("invalid refresh handling wrong");
    chk_window_edge: assert property ($rose(invalid_refresh)
        |-> $past(timer_count) <= {$past(window_boundary_byte), 8'h00})
        else $error("refresh outside window flagged");
    chk_service_load: assert property (srv_ok
        |=> timer_count == {$past(reload_high_byte), 8'h00})
        else $error("service did not reload the counter");
    chk_no_window: assert property (service_req && !window_enable
        |=> $stable(invalid_refresh))
        else $error("refresh refused with window off");

    // Main scenarios reached
    cover property (k_open ##1 write_open);
    cover property ($rose(guard_timer_nmi_request));
    cover property ($rose(invalid_refresh));
    cover property ($rose(guard_timer_reset_request));
endmodule // guard_timer_properties

bind guard_timer_top guard_timer_properties #(.FBDIV_W(FBDIV_W)) u_props (.*);
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for guard_timer_top: lock keys, protected writes, timer.
// Drives every port directly on ref_clk; the checker is bound separately.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import guard_timer_pkg::*;
    localparam logic [7:0] key_open = {PASS_OPEN, 3'h0};
    localparam logic [7:0] key_close = {PASS_CLOSE, 3'h0};
    localparam logic [7:0] key_free = {PASS_MODE, 3'h0};
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic key_wr = 1'b0, prot_wr = 1'b0, service_req = 1'b0;
    logic [7:0] key_wdata = 8'h00, reload_high_byte = 8'h00, window_boundary_byte = 8'h00;
    logic [3:0] pll_feedback_divider_wdata = 4'h0, pll_feedback_divider;
    logic [0:0] pll_output_divider_wdata = 1'h0, pll_output_divider;
    logic guard_timer_enable_wdata = 1'b0, power_down_enable_wdata = 1'b0;
    logic slow_down_enable_wdata = 1'b0, input_prescale_select = 1'b0, window_enable = 1'b0;
    logic guard_timer_enable, power_down_enable, slow_down_enable, write_open;
    logic [1:0] lock_mode;
    logic [15:0] timer_count;
    logic prewarning, invalid_refresh, guard_timer_nmi_request, guard_timer_reset_request;
    int miscompares = 0;
    int comparisons = 0;
    int n;
    int d;
    wire logic [7:0] prot = {pll_feedback_divider, pll_output_divider, guard_timer_enable,
        power_down_enable, slow_down_enable};
    wire logic [3:0] stat = {prewarning, invalid_refresh, guard_timer_nmi_request,
        guard_timer_reset_request};

    guard_timer_top DUT (.*);

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        comparisons++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[ERR] %0t %s took %0d cycles", $time, what, got);
        end
    endtask

    task automatic chk_lock(input logic [7:0] p, input logic [2:0] l);
        chk_val({8'h00, prot}, {8'h00, p}, "protected bits");
        chk_val({13'h0000, write_open, lock_mode}, {13'h0000, l}, "lock state");
    endtask

    task automatic chk_stat(input logic [3:0] s);
        chk_val({12'h000, stat}, {12'h000, s}, "timer status");
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    // One-cycle strobe: 0 key write, 1 protected write, 2 service
    task automatic strobe(input int k, input logic [7:0] v);
        @(posedge ref_clk);
        key_wdata <= v;
        {pll_feedback_divider_wdata, pll_output_divider_wdata, guard_timer_enable_wdata,
            power_down_enable_wdata, slow_down_enable_wdata} <= v;
        key_wr <= k == 0;
        prot_wr <= k == 1;
        service_req <= k == 2;
        @(posedge ref_clk);
        {key_wr, prot_wr, service_req} <= 3'h0;
        @(negedge ref_clk);
    endtask

    task automatic set_cfg(input logic ps, input logic we, input logic [7:0] wb,
        input logic [7:0] rl);
        @(posedge ref_clk);
        input_prescale_select <= ps;
        window_enable <= we;
        window_boundary_byte <= wb;
        reload_high_byte <= rl;
    endtask

    // Reset waits out the two-flop release before any strobe
    task automatic do_reset;
        @(posedge ref_clk);
        reset_n <= 1'b0;
        tick(20);
        reset_n <= 1'b1;
        tick(3);
        @(negedge ref_clk);
    endtask

    // Bounded poll; the limit only guards against a dead status bit
    task automatic wait_stat(input int b);
        n = 0;
        while (stat[b] !== 1'b1 && n < 40000) begin
            @(negedge ref_clk);
            n++;
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset();
        chk_lock(8'h00, 3'h3);
        chk_stat(4'h0);
        strobe(1, 8'hFF);
        chk_lock(8'h00, 3'h3);
        strobe(0, key_open);
        chk_lock(8'h00, 3'h7);
        tick(20);
        strobe(0, key_open);
        tick(30);
        strobe(1, 8'hA5);
        chk_lock(8'hA5, 3'h3);
        strobe(1, 8'h5A);
        strobe(0, key_open);
        strobe(0, key_close);
        strobe(1, 8'h00);
        chk_lock(8'hA5, 3'h3);
        for (int m = 0; m < 4; m++) begin
            strobe(0, {PASS_MODE, 1'b0, 2'(m)});
            strobe(0, key_open);
            chk_lock(8'hA5, 3'(m == 3 ? 7 : m));
        end
        strobe(0, key_close);
        strobe(0, key_free);
        strobe(1, 8'h0B);
        chk_lock(8'h0B, 3'h0);
        $display("test lock done");
        for (int p = 0; p < 2; p++) begin
            d = p ? PRESCALE_SLOW : PRESCALE_FAST;
            do_reset();
            set_cfg(p[0], 1'b0, 8'hFF, 8'hFF);
            strobe(0, key_free);
            strobe(1, 8'h04);
            strobe(2, 8'h00);
            chk_val(timer_count, 16'hFF00, "reload");
            wait_stat(1);
            chk_rng(n, d * 255, d * 257, "overflow");
            chk_stat(4'hA);
            wait_stat(0);
            chk_rng(n, d * 47, d * 49, "prewarning");
            chk_stat(4'h3);
            $display("test timer divide %0d done", d);
        end
        for (int c = 0; c < 3; c++) begin
            do_reset();
            set_cfg(c != 1, c < 2, 8'h80, 8'h80);
            strobe(0, key_free);
            strobe(1, 8'h04);
            if (c == 1) tick(520);
            strobe(2, 8'h00);
            chk_stat(c == 0 ? 4'hC : 4'h0);
            if (c > 0) chk_val(timer_count, 16'h8000, "window reload");
            $display("test window case %0d done", c);
        end
        complete_run();
    end

    // Watchdog: about one and a half times the expected run
    initial begin
        #480000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
